// >>> hw/snoop_regs.svh
// constant names for the bus snoop controller: codes, beat counts, fifo shape
// assumes inclusion by bare name from the controller and its bench
//
// Contract
// - snoop only foreign-master cycles with start strobe
// - capture address and attributes at first strobe edge
// - code zero releases inhibit at once, no lookup
// - read codes: supply dirty, keep or invalidate
// - write codes: sink data or invalidate line
// - code three treated as snoop inhibited
// - only normal and line-move transfers snooped
// - hold memory inhibit throughout the cache lookup
// - intervene only on dirty hit with supply/sink
// - no intervention: release inhibit, memory answers
// - lookup jitter delays release two clocks at most
// - classify termination: normal, error, retry, burst-inhibit
// - burst-inhibited line snooped as four longwords
// - drive page attributes as master to snoopers
// - read supply ignores which longword is dirty
// - line read intervention: ack four longwords, slave
// - write intervention updates line, sets longword dirty
// - write intervention acks and samples data bus
`ifndef SNOOP_REGS_SVH
`define SNOOP_REGS_SVH

`define SC_INHIBIT      2'h0
`define SC_SUPPLY_KEEP  2'h1
`define SC_SUPPLY_INVAL 2'h2
`define SC_RESERVED     2'h3

`define TT_NORMAL       2'h0
`define TT_LINE_MOVE    2'h1

`define SIZ_LONG        2'h0
`define SIZ_BYTE        2'h1
`define SIZ_WORD        2'h2
`define SIZ_LINE        2'h3

`define LINE_BEATS      3'h4
`define SINGLE_BEAT     3'h1
`define LOOKUP_MAX_CLKS 3'h4

`define SINK_WIDTH      66
`define SINK_DEPTH      32

`endif

// >>> hw/snoop_pkg.sv
// types shared by the snoop controller files
// assumes no other package in scope
package snoop_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_LOOKUP  = 4'h1,
    ST_RD_REQ  = 4'h2,
    ST_RD_WAIT = 4'h3,
    ST_RD_BEAT = 4'h4,
    ST_WR_ACK  = 4'h5,
    ST_WR_TAKE = 4'h6,
    ST_DONE    = 4'h7,
    ST_TERM    = 4'h8
  } snoop_state_t;

  typedef enum logic [1:0] {
    TERM_NORMAL    = 2'h0,
    TERM_ERROR     = 2'h1,
    TERM_RETRY     = 2'h2,
    TERM_BURST_INH = 2'h3
  } term_t;

endpackage

// >>> hw/sink_fifo.sv
// first-in first-out buffer for sunk write beats, registered read side
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module sink_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  wire              push;
  wire              load;

  // the output register refills whenever storage holds a beat and the register is empty or being taken
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign push      = in_valid && in_ready;
  assign load      = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // storage and output data have no reset; only pointers, count and valid flag are reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
    if (load) begin
      out_data_r <= mem[rd_ptr_r];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      cnt_r       <= '0;
      out_valid_r <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (load) rd_ptr_r <= rd_ptr_r + 1'b1;
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      if (load) out_valid_r <= 1'b1;
      else if (out_ready) out_valid_r <= 1'b0;
    end
  end

endmodule // sink_fifo

`default_nettype wire

// >>> hw/bus_snoop_controller.sv
// bus snoop controller: watches foreign-master cycles, inhibits memory while
// the data cache is searched, and intervenes as a slave on dirty hits it must supply or sink.
// assumes the bus pins are synchronous to core_clk (the bus clock) and a
// data cache that answers lookups within a few clocks.
`timescale 1ns/100ps
`default_nettype none
`include "snoop_regs.svh"

module bus_snoop_controller
  import snoop_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // bus side
  input  wire logic        other_owns_bus,
  input  wire logic        xfer_start_strobe_n,
  input  wire logic [31:0] addr_lines,
  input  wire logic [1:0]  xfer_size_bits,
  input  wire logic [1:0]  xfer_type_bits,
  input  wire logic        read_write,
  input  wire logic [1:0]  snoop_ctrl_code,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic             data_oe_n,
  input  wire logic        xfer_ack_n_in,
  output logic             xfer_ack_n_out,
  output logic             xfer_ack_oe_n,
  input  wire logic        xfer_error_ack_n,
  input  wire logic        burst_inhibit_ind_n,
  output logic             memory_inhibit_n,
  output logic      [1:0]  page_user_attr_out,
  output logic             page_attr_oe_n,
  output logic      [1:0]  term_class,
  output logic             term_valid,
  // own mastership and page attribute from translation
  input  wire logic        own_bus,
  input  wire logic [1:0]  page_attr,
  // data cache side
  output logic             cache_lookup_req,
  output logic      [31:0] cache_lookup_addr,
  input  wire logic        cache_lookup_done,
  input  wire logic        cache_hit,
  input  wire logic        cache_dirty,
  output logic             cache_rd_req,
  output logic      [31:0] cache_rd_addr,
  input  wire logic        cache_rd_valid,
  input  wire logic [31:0] cache_rd_data,
  output logic             cache_inval,
  output logic             cache_wr_valid,
  input  wire logic        cache_wr_ready,
  output logic      [31:0] cache_wr_addr,
  output logic      [3:0]  cache_wr_be,
  output logic      [31:0] cache_wr_data
);

  snoop_state_t state_r;
  snoop_state_t state_nxt;
  logic [31:0]  cap_addr_r;
  logic [1:0]   cap_size_r;
  logic         cap_read_r;
  logic [1:0]   cap_sc_r;
  logic         intervene_r;
  logic [2:0]   beat_r;
  logic         inhib_n_r;
  logic         lookup_req_r;
  logic         rd_req_r;
  logic [31:0]  rd_addr_r;
  logic         inval_r;
  logic [31:0]  dout_r;
  logic         doe_n_r;
  logic         ack_n_r;
  logic         ack_oe_n_r;
  logic [1:0]   upa_r;
  logic         upa_oe_n_r;
  logic [1:0]   term_class_r;
  logic         term_valid_r;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic [65:0]  fifo_out_data;

  // decode of the live bus at the strobe edge
  wire start_seen  = other_owns_bus && !xfer_start_strobe_n;
  wire sc_enabled  = (snoop_ctrl_code == `SC_SUPPLY_KEEP) ||
                     (snoop_ctrl_code == `SC_SUPPLY_INVAL);
  wire tt_snoop    = (xfer_type_bits == `TT_NORMAL) ||
                     (xfer_type_bits == `TT_LINE_MOVE);
  wire snoop_now   = sc_enabled && tt_snoop;

  // decode of the captured cycle once the cache has answered
  wire dirty_hit   = cache_lookup_done && cache_hit && cache_dirty;
  wire want_data   = cap_read_r || (cap_sc_r == `SC_SUPPLY_KEEP);
  wire do_interv   = dirty_hit && want_data;
  wire wr_inval    = cache_lookup_done && cache_hit && !cap_read_r &&
                     (cap_sc_r == `SC_SUPPLY_INVAL);
  wire is_line     = (cap_size_r == `SIZ_LINE);
  wire [2:0] beats = is_line ? `LINE_BEATS : `SINGLE_BEAT;
  wire last_beat   = (beat_r + 3'h1) == beats;
  // line beats wrap inside the line on address bits 3:2
  wire [31:0] beat_addr = {cap_addr_r[31:4], cap_addr_r[3:2] + beat_r[1:0], 2'b00};
  wire [3:0]  bus_be    = byte_enables(cap_size_r, cap_addr_r[1:0]);
  wire        fifo_push = (state_r == ST_WR_TAKE);
  wire [65:0] fifo_in   = {beat_addr[31:2], bus_be, data_in};
  wire ended       = !xfer_ack_n_in || !xfer_error_ack_n;
  wire [1:0] term_code = classify(xfer_ack_n_in, xfer_error_ack_n, burst_inhibit_ind_n);

  // big-endian lane selection; byte 0 sits on the top lane
  function automatic logic [3:0] byte_enables(input logic [1:0] siz,
                                              input logic [1:0] a);
    logic [3:0] be;
    be = 4'hF;
    if (siz == `SIZ_BYTE) be = 4'h8 >> a;
    else if (siz == `SIZ_WORD) be = a[1] ? 4'h3 : 4'hC;
    return be;
  endfunction

  // both acks at once ask for a retry; burst inhibit only matters with ack
  function automatic logic [1:0] classify(input logic ack_n, input logic err_n,
                                          input logic inh_n);
    logic [1:0] c;
    c = TERM_NORMAL;
    if (!ack_n && !err_n) c = TERM_RETRY;
    else if (!err_n) c = TERM_ERROR;
    else if (!inh_n) c = TERM_BURST_INH;
    return c;
  endfunction

  // sequencing of one snooped cycle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_seen) state_nxt = snoop_now ? ST_LOOKUP : ST_TERM;
      end
      ST_LOOKUP: begin
        if (cache_lookup_done) begin
          if (do_interv) state_nxt = cap_read_r ? ST_RD_REQ : ST_WR_ACK;
          else state_nxt = ST_TERM;
        end
      end
      ST_RD_REQ:  state_nxt = ST_RD_WAIT;
      ST_RD_WAIT: if (cache_rd_valid) state_nxt = ST_RD_BEAT;
      ST_RD_BEAT: state_nxt = last_beat ? ST_DONE : ST_RD_REQ;
      ST_WR_ACK:  if (fifo_in_ready) state_nxt = ST_WR_TAKE;
      ST_WR_TAKE: state_nxt = last_beat ? ST_DONE : ST_WR_ACK;
      ST_DONE:    state_nxt = ST_IDLE;
      ST_TERM:    if (ended && (!is_line || last_beat || term_code != TERM_NORMAL))
                    state_nxt = ST_IDLE;
      default:    state_nxt = ST_IDLE;
    endcase
  end

  // state, capture and beat count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      cap_addr_r  <= 32'h0000_0000;
      cap_size_r  <= 2'h0;
      cap_read_r  <= 1'b0;
      cap_sc_r    <= 2'h0;
      intervene_r <= 1'b0;
      beat_r      <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && start_seen) begin
        cap_addr_r <= addr_lines;
        cap_size_r <= xfer_size_bits;
        cap_read_r <= read_write;
        cap_sc_r   <= snoop_ctrl_code;
        beat_r     <= 3'h0;
      end else if (state_r == ST_RD_BEAT || state_r == ST_WR_TAKE ||
                   (state_r == ST_TERM && !xfer_ack_n_in)) begin
        beat_r <= beat_r + 3'h1;
      end
      if (state_r == ST_LOOKUP && cache_lookup_done) intervene_r <= do_interv;
      else if (state_r == ST_IDLE) intervene_r <= 1'b0;
    end
  end

  // memory inhibit: asserted at the strobe edge for snooped cycles and held
  // through the search; a release waits on the cache, so lookup jitter
  // shows up one for one in the release time
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      inhib_n_r <= 1'b1;
    end else if (state_r == ST_IDLE && start_seen) begin
      inhib_n_r <= !snoop_now;
    end else if (state_r == ST_LOOKUP && cache_lookup_done && !do_interv) begin
      inhib_n_r <= 1'b1;
    end else if (state_r == ST_DONE) begin
      inhib_n_r <= 1'b1;
    end
  end

  // cache requests: lookup, longword read, invalidate
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lookup_req_r <= 1'b0;
      rd_req_r     <= 1'b0;
      rd_addr_r    <= 32'h0000_0000;
      inval_r      <= 1'b0;
    end else begin
      lookup_req_r <= (state_r == ST_IDLE) && start_seen && snoop_now;
      rd_req_r     <= (state_r == ST_RD_REQ);
      if (state_r == ST_RD_REQ) rd_addr_r <= beat_addr;
      // invalidate only on a taken snoop; all else leaves the line alone
      inval_r <= (state_r == ST_LOOKUP && wr_inval) ||
                 (state_r == ST_DONE && cap_read_r &&
                  cap_sc_r == `SC_SUPPLY_INVAL);
    end
  end

  // slave drive of data and ack; lanes released a cycle after the last beat
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dout_r     <= 32'h0000_0000;
      doe_n_r    <= 1'b1;
      ack_n_r    <= 1'b1;
      ack_oe_n_r <= 1'b1;
    end else begin
      if (state_r == ST_RD_WAIT && cache_rd_valid) begin
        dout_r  <= cache_rd_data;
        doe_n_r <= 1'b0;
      end else if (state_r == ST_DONE) begin
        doe_n_r <= 1'b1;
      end
      ack_n_r <= !((state_r == ST_RD_WAIT && cache_rd_valid) ||
                   (state_r == ST_WR_ACK && fifo_in_ready));
      if (state_r == ST_RD_WAIT || state_r == ST_WR_ACK) ack_oe_n_r <= 1'b0;
      else if (state_r == ST_DONE) ack_oe_n_r <= 1'b1;
    end
  end

  // termination watch for cycles memory answers; each burst-inhibited
  // longword arrives with its own strobe and is snooped afresh
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      term_class_r <= TERM_NORMAL;
      term_valid_r <= 1'b0;
    end else begin
      term_valid_r <= (state_r == ST_TERM) && ended;
      if (state_r == ST_TERM && ended) term_class_r <= term_code;
    end
  end

  // page attributes go out only while this device masters the bus
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      upa_r      <= 2'h0;
      upa_oe_n_r <= 1'b1;
    end else begin
      upa_r      <= own_bus ? page_attr : 2'h0;
      upa_oe_n_r <= !own_bus;
    end
  end

  // sunk write beats queue here so a slow cache stalls the bus ack only once the queue is full
  sink_fifo #(
    .WIDTH (`SINK_WIDTH),
    .DEPTH (`SINK_DEPTH)
  ) u_sink (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (cache_wr_ready),
    .out_data  (fifo_out_data)
  );

  // outputs
  assign data_out           = dout_r;
  assign data_oe_n          = doe_n_r;
  assign xfer_ack_n_out     = ack_n_r;
  assign xfer_ack_oe_n      = ack_oe_n_r;
  assign memory_inhibit_n   = inhib_n_r;
  assign page_user_attr_out = upa_r;
  assign page_attr_oe_n     = upa_oe_n_r;
  assign term_class         = term_class_r;
  assign term_valid         = term_valid_r;
  assign cache_lookup_req   = lookup_req_r;
  assign cache_lookup_addr  = cap_addr_r;
  assign cache_rd_req       = rd_req_r;
  assign cache_rd_addr      = rd_addr_r;
  assign cache_inval        = inval_r;
  assign cache_wr_valid     = fifo_out_valid;
  assign cache_wr_addr      = {fifo_out_data[65:36], 2'b00};
  assign cache_wr_be        = fifo_out_data[35:32];
  assign cache_wr_data      = fifo_out_data[31:0];

  // helper: acks driven during one intervention, and cycles spent searching
  logic [2:0] ack_cnt_r;
  logic [2:0] look_cnt_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n || state_r == ST_IDLE) begin
      ack_cnt_r  <= 3'h0;
      look_cnt_r <= 3'h0;
    end else begin
      if (!ack_n_r) ack_cnt_r <= ack_cnt_r + 3'h1;
      if (state_r == ST_LOOKUP && look_cnt_r != 3'h7) look_cnt_r <= look_cnt_r + 3'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_START_OWNER: assert property (
    state_r == ST_IDLE && state_nxt != ST_IDLE |-> other_owns_bus && !xfer_start_strobe_n)
    else $error("snoop started without a foreign strobe");

  AST_CAPTURE: assert property (
    state_r == ST_IDLE && start_seen |=> cap_addr_r == $past(addr_lines) &&
      cap_sc_r == $past(snoop_ctrl_code) && cap_size_r == $past(xfer_size_bits))
    else $error("cycle attributes not captured at the strobe edge");

  AST_INHIBIT_FREE: assert property (
    state_r == ST_IDLE && start_seen && snoop_ctrl_code == `SC_INHIBIT
      |=> inhib_n_r && !lookup_req_r && state_r == ST_TERM)
    else $error("snoop-inhibited cycle looked up or held memory");

  AST_RESERVED: assert property (
    state_r == ST_IDLE && start_seen && snoop_ctrl_code == `SC_RESERVED
      |=> inhib_n_r && !lookup_req_r)
    else $error("reserved code was snooped");

  AST_TYPE_FILTER: assert property (
    state_r == ST_IDLE && start_seen && !tt_snoop |=> !lookup_req_r ##1 !lookup_req_r)
    else $error("unsnoopable transfer type was looked up");

  AST_INHIBIT_HELD: assert property (
    state_r == ST_LOOKUP |-> !inhib_n_r)
    else $error("memory inhibit dropped during lookup");

  AST_NO_INTERVENE: assert property (
    state_r == ST_LOOKUP && cache_lookup_done && !do_interv |=> inhib_n_r && ack_oe_n_r)
    else $error("inhibit not released after a miss");

  AST_ACK_ONLY_INTERVENE: assert property (
    !ack_oe_n_r |-> intervene_r)
    else $error("ack driven without a dirty hit");

  AST_LINE_BEATS: assert property (
    state_r == ST_DONE && cap_read_r && is_line |-> ack_cnt_r == 3'h4)
    else $error("line read intervention did not ack four longwords");

  AST_SINK_ON_ACK: assert property (
    fifo_push |-> !ack_n_r && doe_n_r)
    else $error("write data sampled without our ack");

  AST_INVAL_SOURCE: assert property (
    inval_r |-> cap_sc_r == `SC_SUPPLY_INVAL)
    else $error("line invalidated by a code that keeps it");

  AST_LOOKUP_SPAN: assert property (
    state_r == ST_LOOKUP && cache_lookup_done |-> look_cnt_r < `LOOKUP_MAX_CLKS)
    else $error("lookup ran past best case plus two");

  COV_READ_INTERV: cover property (state_r == ST_RD_BEAT ##[1:20] state_r == ST_DONE);
  COV_WRITE_SINK:  cover property (fifo_push ##[1:10] cache_wr_valid);
  COV_INHIBITED:   cover property (state_r == ST_IDLE && start_seen && !snoop_now);
  COV_TERM_ERROR:  cover property (term_valid_r && term_class_r == TERM_ERROR);

endmodule // bus_snoop_controller

`default_nettype wire

// >>> sim/snoop_cache_model.sv
// data cache stand-in: answers lookups, reads and a stallable write port
// assumes one clock shared with the controller and no reset of its own
`timescale 1ns/100ps
`default_nettype none

module snoop_cache_model (
  input  wire logic        core_clk,
  input  wire logic        cache_lookup_req,
  input  wire logic [1:0]  lat,
  input  wire logic        hit_cfg,
  input  wire logic        dirty_cfg,
  output logic             cache_lookup_done,
  output logic             cache_hit,
  output logic             cache_dirty,
  input  wire logic        cache_rd_req,
  input  wire logic [31:0] cache_rd_addr,
  output logic             cache_rd_valid,
  output logic      [31:0] cache_rd_data,
  input  wire logic        cache_inval,
  input  wire logic        cache_wr_valid,
  input  wire logic        stall,
  output logic             cache_wr_ready,
  input  wire logic [31:0] cache_wr_data,
  output int               n_lk,
  output int               n_wr,
  output int               n_inv,
  output logic      [31:0] last_wr
);
  logic [1:0]      cnt_r;
  wire logic [1:0] cnt_nxt = cache_lookup_req ? lat : cnt_r;

  // hit and dirty mean something only in the done cycle, so they lie outside it
  assign cache_hit      = cache_lookup_done ? hit_cfg : ~hit_cfg;
  assign cache_dirty    = cache_lookup_done ? dirty_cfg : ~dirty_cfg;
  assign cache_wr_ready = ~stall;

  initial begin
    {cnt_r, cache_lookup_done, cache_rd_valid, cache_rd_data, last_wr} = '0;
    {n_lk, n_wr, n_inv} = '0;
  end

  // lookup answers 1 to 3 clocks after the request; read data scrambles the address
  always @(posedge core_clk) begin
    cache_lookup_done <= (cnt_nxt == 2'h1);
    cnt_r             <= (cnt_nxt == 2'h0) ? 2'h0 : cnt_nxt - 2'h1;
    cache_rd_valid    <= cache_rd_req;
    cache_rd_data     <= cache_rd_req ? ({cache_rd_addr[31:2], 2'h0} ^ 32'h5A5AC3C3) : ~cache_rd_data;
    n_lk              <= n_lk + int'(cache_lookup_req);
    n_inv             <= n_inv + int'(cache_inval);
    if (cache_wr_valid && cache_wr_ready) begin
      n_wr    <= n_wr + 1;
      last_wr <= cache_wr_data;
    end
  end
endmodule // snoop_cache_model
`default_nettype wire

// >>> sim/tb_bus_snoop_controller.sv
// self-checking bench: the bench plays alternate master and memory
// assumes the controller and the cache model are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "snoop_regs.svh"

module tb_bus_snoop_controller;
  import snoop_pkg::*;
  logic        core_clk, rst_n, other_owns_bus, xfer_start_strobe_n, read_write, own_bus;
  logic        data_oe_n, xfer_ack_n_out, xfer_ack_oe_n, mem_ack_n, xfer_error_ack_n;
  logic        burst_inhibit_ind_n, memory_inhibit_n, page_attr_oe_n, term_valid, stall;
  logic        cache_lookup_req, cache_lookup_done, cache_hit, cache_dirty, hit_cfg, dirty_cfg;
  logic        cache_rd_req, cache_rd_valid, cache_inval, cache_wr_valid, cache_wr_ready;
  logic [1:0]  xfer_size_bits, xfer_type_bits, snoop_ctrl_code, page_user_attr_out;
  logic [1:0]  term_class, page_attr, lat;
  logic [31:0] addr_lines, bus_d, data_out, cache_lookup_addr, cache_rd_addr;
  logic [31:0] cache_rd_data, cache_wr_data, cache_wr_addr, last_wr;
  logic [3:0]  cache_wr_be;
  int          n_lk, n_wr, n_inv, w0, n_mismatch = 0, n_compared = 0;
  // ack and data wires resolve between bench memory and the controller
  wire logic        xfer_ack_n_in = xfer_ack_oe_n ? mem_ack_n : xfer_ack_n_out;
  wire logic [31:0] data_in       = data_oe_n ? bus_d : data_out;

  bus_snoop_controller i_bus_snoop_controller (
    .core_clk, .rst_n, .other_owns_bus, .xfer_start_strobe_n, .addr_lines, .xfer_size_bits,
    .xfer_type_bits, .read_write, .snoop_ctrl_code, .data_in, .data_out, .data_oe_n,
    .xfer_ack_n_in, .xfer_ack_n_out, .xfer_ack_oe_n, .xfer_error_ack_n, .burst_inhibit_ind_n,
    .memory_inhibit_n, .page_user_attr_out, .page_attr_oe_n, .term_class, .term_valid,
    .own_bus, .page_attr, .cache_lookup_req, .cache_lookup_addr, .cache_lookup_done,
    .cache_hit, .cache_dirty, .cache_rd_req, .cache_rd_addr, .cache_rd_valid, .cache_rd_data,
    .cache_inval, .cache_wr_valid, .cache_wr_ready, .cache_wr_addr, .cache_wr_be,
    .cache_wr_data);

  snoop_cache_model i_snoop_cache_model (
    .core_clk, .cache_lookup_req, .lat, .hit_cfg, .dirty_cfg, .cache_lookup_done, .cache_hit,
    .cache_dirty, .cache_rd_req, .cache_rd_addr, .cache_rd_valid, .cache_rd_data, .cache_inval,
    .cache_wr_valid, .stall, .cache_wr_ready, .cache_wr_data, .n_lk, .n_wr, .n_inv, .last_wr);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // inputs change 1 ns after the rising edge, outputs are settled by then
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // one alternate-master access; memory answers only once inhibit is released
  task automatic snoop(input logic [1:0] c, t, s, input logic r, h, d, input int term, rel);
    logic [31:0] a, w, q[$];
    logic [3:0]  be;
    int          beats, lk0, wr0, inv0, low, acks, mem, tseen;
    bit          sn, iv, done, drv;
    a = $urandom;
    w = $urandom;
    beats = (s == `SIZ_LINE) ? 4 : 1;
    sn = (c == `SC_SUPPLY_KEEP || c == `SC_SUPPLY_INVAL) && t < 2'h2;
    iv = sn && h && d && (r || c == `SC_SUPPLY_KEEP);
    // byte lanes are big-endian: byte 0 rides the top lane
    be = (s == `SIZ_BYTE) ? 4'h8 >> a[1:0] : (s == `SIZ_WORD) ? (a[1] ? 4'h3 : 4'hC) : 4'hF;
    for (int k = 0; k < beats; k++)
      q.push_back({a[31:4], a[3:2] + 2'(k), 2'h0} ^ 32'h5A5AC3C3);
    {lk0, wr0, inv0, low, acks, mem, tseen, done} = '0;
    {hit_cfg, dirty_cfg, lat} = {h, d, 2'($urandom_range(1, 3))};
    {addr_lines, xfer_size_bits, xfer_type_bits, read_write, snoop_ctrl_code} = {a, s, t, r, c};
    {lk0, wr0, inv0, bus_d, other_owns_bus, xfer_start_strobe_n} = {n_lk, n_wr, n_inv, w, 2'h2};
    tick;
    xfer_start_strobe_n = 1'b1;
    addr_lines = ~a;
    chk("inhibit", 32'(!sn), 32'(memory_inhibit_n));
    if (sn) chk("lookup_addr", a, cache_lookup_addr);
    for (int i = 0; i < 90 && !done; i++) begin
      if (i == rel) stall = 1'b0;
      if (!memory_inhibit_n) low++;
      if (!xfer_ack_oe_n && !xfer_ack_n_out) begin
        if (i < rel && rel < 99) chk("early_ack", 0, 1);
        if (r) chk("read_data", q.pop_front(), data_out);
        if (r) chk("read_oe", 0, data_oe_n);
        acks++;
      end
      if (term_valid) begin
        tseen++;
        chk("term_class", term, 32'(term_class));
      end
      // memory holds off while any inhibit is low
      drv = !iv && memory_inhibit_n && mem < beats;
      mem_ack_n = !(drv && term != 1);
      xfer_error_ack_n = !(drv && (term == 1 || term == 2));
      burst_inhibit_ind_n = !(drv && term == 3);
      if (drv) mem = (term == 0) ? mem + 1 : beats;
      // a memory-answered cycle ends once every beat's class pulse has passed
      done = iv ? (acks == beats && memory_inhibit_n)
                : (mem >= beats && tseen > 0 && !term_valid);
      tick;
    end
    if (!done) begin
      n_mismatch++;
      $display("ERROR snoop_wait expected done seen timeout");
      print_verdict;
    end
    if (!iv) chk("inhibit_span", sn ? lat + 1 : 0, low);
    chk("own_acks", iv ? beats : 0, acks);
    chk("terms", iv ? 0 : (term == 0 ? beats : 1), tseen);
    repeat (4) tick;
    chk("lookups", 32'(sn), n_lk - lk0);
    chk("invals", 32'(sn && h && c == `SC_SUPPLY_INVAL && (d || !r)), n_inv - inv0);
    if (rel == 0) chk("writes", 32'(iv && !r), n_wr - wr0);
    if (rel == 0 && iv && !r) chk("sunk_data", w, last_wr);
    if (rel == 0 && iv && !r) chk("sunk_addr", {a[31:2], 2'h0}, cache_wr_addr);
    if (rel == 0 && iv && !r) chk("sunk_be", 32'(be), 32'(cache_wr_be));
  endtask

  initial begin
    {rst_n, other_owns_bus, own_bus, read_write, stall, hit_cfg, dirty_cfg} = '0;
    {xfer_start_strobe_n, mem_ack_n, xfer_error_ack_n, burst_inhibit_ind_n} = 4'hF;
    {addr_lines, bus_d, xfer_size_bits, xfer_type_bits, snoop_ctrl_code, page_attr} = '0;
    lat = 2'h1;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    void'($urandom(32'hBD76));
    chk("reset_outputs", 5'h1E, {memory_inhibit_n, data_oe_n, xfer_ack_oe_n, page_attr_oe_n, term_valid});
    // every code, direction and miss / clean hit / dirty hit
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 2; r++)
        for (int hd = 0; hd < 3; hd++)
          snoop(2'(c), `TT_NORMAL, 2'($urandom_range(0, r ? 3 : 2)), r[0], hd > 0, hd == 2,
                $urandom_range(0, 3), 0);
    $display("test codes done");
    for (int t = 0; t < 4; t++)
      snoop(`SC_SUPPLY_KEEP, 2'(t), `SIZ_LINE, 1'b1, 1'b1, 1'b1, 0, 0);
    $display("test transfer types done");
    // line terminations, then the four burst-inhibited longwords snooped alone
    for (int m = 0; m < 4; m++)
      snoop(`SC_INHIBIT, `TT_NORMAL, `SIZ_LINE, 1'b1, 1'b0, 1'b0, m, 0);
    for (int k = 0; k < 4; k++)
      snoop(`SC_SUPPLY_INVAL, `TT_NORMAL, `SIZ_LONG, 1'b1, 1'b1, 1'b1, 0, 0);
    $display("test terminations done");
    // strobe while the bus is not foreign: nothing may happen
    w0 = n_lk;
    {other_owns_bus, snoop_ctrl_code, xfer_start_strobe_n} = {1'b0, `SC_SUPPLY_KEEP, 1'b0};
    tick;
    xfer_start_strobe_n = 1'b1;
    repeat (5) begin
      chk("idle_inhibit", 1, 32'(memory_inhibit_n));
      tick;
    end
    chk("idle_lookups", 0, n_lk - w0);
    $display("test foreign ownership done");
    // stalled write port: 33 sinks fit, the 34th waits for the drain
    w0 = n_wr;
    stall = 1'b1;
    for (int k = 0; k < 34; k++)
      snoop(`SC_SUPPLY_KEEP, `TT_NORMAL, `SIZ_LONG, 1'b0, 1'b1, 1'b1, 0, k == 33 ? 12 : 999);
    for (int i = 0; i < 200 && n_wr - w0 < 34; i++)
      tick;
    chk("drained", 34, n_wr - w0);
    $display("test sink buffer done");
    own_bus = 1'b1;
    page_attr = 2'($urandom);
    repeat (2) tick;
    chk("page_attr", {page_attr, 1'b0}, {page_user_attr_out, page_attr_oe_n});
    own_bus = 1'b0;
    repeat (2) tick;
    chk("page_attr_off", 1, 32'(page_attr_oe_n));
    $display("test page attributes done");
    print_verdict;
  end
endmodule // tb_bus_snoop_controller
`default_nettype wire
